// ==== verilog/qpc_pkg.sv ====
package qpc_pkg;

   // counter widths
   localparam int POS_W = 16;
   localparam int IDX_W = 16;
   localparam int SLOTS = 3;

   // register byte addresses
   localparam logic [7:0] ADDR_CTRL     = 8'h00;
   localparam logic [7:0] ADDR_MAXPOS   = 8'h04;
   localparam logic [7:0] ADDR_POS      = 8'h08;
   localparam logic [7:0] ADDR_IDX      = 8'h0C;
   localparam logic [7:0] ADDR_COND     = 8'h10;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
   localparam logic [7:0] ADDR_IRQ_EN   = 8'h18;
   localparam logic [7:0] ADDR_IRQ_CLR  = 8'h1C;
   localparam logic [7:0] ADDR_CMP_BASE = 8'h20;
   localparam logic [7:0] ADDR_CMP_STEP = 8'h04;

   // control register fields
   localparam int CTRL_EN_BIT   = 0;
   localparam int CTRL_RPOS_BIT = 1;
   localparam int CTRL_RIDX_BIT = 2;

   // compare slot word: [15:0] first value, [31:16] second value
   localparam int CMP_FIRST_LSB  = 0;
   localparam int CMP_SECOND_LSB = 16;

   // interrupt status bits
   localparam int EV_FWD_WRAP = 0;
   localparam int EV_REV_WRAP = 1;
   localparam int EV_MATCH    = 2;
   localparam int EV_W        = 3;

   localparam logic [POS_W-1:0] MAXPOS_RST = 16'hFFFF;

   // condition word: enabled, moving, last wrap direction
   typedef struct packed
   {
      logic moving;
      logic last_wrap_rev;
      logic enabled;
   } qpc_cond_type;

   // decoded quadrature step
   typedef struct packed
   {
      logic step;
      logic fwd;
   } qpc_step_type;

   // compare slot values
   typedef struct packed
   {
      logic [IDX_W-1:0] second;
      logic [POS_W-1:0] first;
   } qpc_cmp_type;

endpackage

// ==== verilog/qpc_sync.sv ====
`timescale 1ns/1ps
// three-stage synchroniser for the encoder pins
module qpc_sync
   import qpc_pkg::*;
#(
   parameter int W = 2
)
(
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic         ce,
   input  wire logic [W-1:0] pin,
   output logic      [W-1:0] s2,
   output logic      [W-1:0] s3
);

   logic [W-1:0] s1_r;

   // s1 feeds only s2; s2 and s3 are the agreed pair
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         s1_r <= '0;
         s2   <= '0;
         s3   <= '0;
      end
      else if (ce)
      begin
         s1_r <= pin;
         s2   <= s1_r;
         s3   <= s2;
      end
   end

endmodule // qpc_sync

// ==== verilog/qpc_decode.sv ====
`timescale 1ns/1ps
// x4 quadrature decoder; step when the agreed state moves by one gray code
module qpc_decode
   import qpc_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic         ce,
   input  wire logic [1:0]   ab_s2,
   input  wire logic [1:0]   ab_s3,
   output qpc_step_type      step
);

   logic [1:0] prev_r;
   wire        agree = (ab_s2 == ab_s3);
   wire        chg   = agree && (ab_s3 != prev_r);
   // forward when b_new equals a_old inverted... encoded as a^b' pattern
   wire        fwd   = ab_s3[1] ^ prev_r[0];
   wire        legal = ^(ab_s3 ^ prev_r); // one bit changed only

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         prev_r <= 2'h0;
      else if (ce && chg)
         prev_r <= ab_s3;
   end

   // illegal double changes are dropped, not counted
   assign step.step = chg && legal;
   assign step.fwd  = fwd;

endmodule // qpc_decode

// ==== verilog/qpc_top.sv ====
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ps
// Overview of operation
// - block-true output high whenever enabled; counting frozen while enable is low
// - while reset-position is true the position counter clears to zero
// - while reset-index is true the index counter clears to zero
// - travel-sense output shows direction of the last encoder step counted while enabled
// - position and index counts presented on their value outputs
// - forward past maximum sets position zero and increments index
// - reverse reaching zero reloads maximum and decrements index
// - multi-bit condition output reports encoder interface status
// - three position slots match when position equals first value
// - three index slots match when index equals first value
// - three joint slots match when position and index both equal
module qpc_top
   import qpc_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              resetn,
   input  wire logic              clk_en,
   input  wire logic [1:0]        enc_ab,
   input  wire logic              enable_in,
   input  wire logic              reset_position_in,
   input  wire logic              reset_index_in,
   input  wire logic [7:0]        reg_addr,
   input  wire logic [31:0]       reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [31:0]       reg_rdata,
   output logic                   block_true_out,
   output logic                   travel_sense_out,
   output qpc_cond_type           encoder_condition_out,
   output logic      [POS_W-1:0]  position_value_out,
   output logic      [IDX_W-1:0]  index_value_out,
   output logic      [SLOTS-1:0]  position_match_slot,
   output logic      [SLOTS-1:0]  index_match_slot,
   output logic      [SLOTS-1:0]  joint_match_slot,
   output logic                   irq
);

   // software control and configuration
   logic [2:0]        ctrl_r;
   logic [POS_W-1:0]  maxpos_r;
   logic [EV_W-1:0]   stat_r;
   logic [EV_W-1:0]   ien_r;
   qpc_cmp_type       pcmp_r [SLOTS];
   qpc_cmp_type       icmp_r [SLOTS];
   qpc_cmp_type       jcmp_r [SLOTS];

   // counters and state
   logic [POS_W-1:0]  pos_r;
   logic [POS_W-1:0]  pos_nxt;
   logic [IDX_W-1:0]  idx_r;
   logic [IDX_W-1:0]  idx_nxt;
   logic              dir_r;
   logic              last_rev_r;
   logic              en_s2;
   logic              en_s3;
   logic              en_ok_r;
   logic [2:0]        rq_s2;
   logic [2:0]        rq_s3;
   logic [2:0]        rq_ok_r;
   logic [1:0]        ab_s2;
   logic [1:0]        ab_s3;
   qpc_step_type      stp;

   // pins from outside the clock domain
   qpc_sync #(.W(5)) u_sync
   (
      .clk    (clk),
      .resetn (resetn),
      .ce     (clk_en),
      .pin    ({reset_index_in, reset_position_in, enable_in, enc_ab}),
      .s2     ({rq_s2[2:1], en_s2, ab_s2}),
      .s3     ({rq_s3[2:1], en_s3, ab_s3})
   );
   assign rq_s2[0] = 1'b0;
   assign rq_s3[0] = 1'b0;

   qpc_decode u_dec
   (
      .clk    (clk),
      .resetn (resetn),
      .ce     (clk_en),
      .ab_s2  (ab_s2),
      .ab_s3  (ab_s3),
      .step   (stp)
   );

   // a level counts once stages two and three agree
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         en_ok_r <= 1'b0;
         rq_ok_r <= 3'h0;
      end
      else if (clk_en)
      begin
         if (en_s2 == en_s3)
            en_ok_r <= en_s3;
         if (rq_s2[1] == rq_s3[1])
            rq_ok_r[1] <= rq_s3[1];
         if (rq_s2[2] == rq_s3[2])
            rq_ok_r[2] <= rq_s3[2];
      end
   end

   // effective controls: pin or register bit
   wire enabled = en_ok_r | ctrl_r[CTRL_EN_BIT];
   wire rst_pos = rq_ok_r[1] | ctrl_r[CTRL_RPOS_BIT];
   wire rst_idx = rq_ok_r[2] | ctrl_r[CTRL_RIDX_BIT];
   wire cnt     = enabled && stp.step;
   wire at_max  = (pos_r >= maxpos_r);
   wire at_zero = (pos_r <= POS_W'(1));  // a reverse step from here reloads the maximum
   wire fwd_wrap = cnt && stp.fwd && at_max;
   wire rev_wrap = cnt && !stp.fwd && at_zero;

   // position and index next values; reset requests dominate
   always_comb
   begin
      pos_nxt = pos_r;
      idx_nxt = idx_r;
      if (cnt)
      begin
         if (stp.fwd)
         begin
            if (at_max)
            begin
               pos_nxt = '0;
               idx_nxt = idx_r + 1'b1;
            end
            else
               pos_nxt = pos_r + 1'b1;
         end
         else if (at_zero)
         begin
            pos_nxt = maxpos_r;
            idx_nxt = idx_r - 1'b1;
         end
         else
            pos_nxt = pos_r - 1'b1;
      end
      if (rst_pos)
         pos_nxt = '0;
      if (rst_idx)
         idx_nxt = '0;
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pos_r      <= '0;
         idx_r      <= '0;
         dir_r      <= 1'b0;
         last_rev_r <= 1'b0;
      end
      else if (clk_en)
      begin
         pos_r <= pos_nxt;
         idx_r <= idx_nxt;
         if (cnt)
            dir_r <= stp.fwd;
         if (fwd_wrap | rev_wrap)
            last_rev_r <= rev_wrap;
      end
   end

   // compare: slot i hits (first value equality etc.)
   function automatic logic hit_pos(qpc_cmp_type c, logic [POS_W-1:0] p);
      hit_pos = (c.first == p);
   endfunction

   logic [SLOTS-1:0] pm;
   logic [SLOTS-1:0] im;
   logic [SLOTS-1:0] jm;
   generate
      for (genvar i = 0; i < SLOTS; i++)
      begin : g_cmp
         assign pm[i] = hit_pos(pcmp_r[i], pos_r);
         assign im[i] = (icmp_r[i].first == idx_r);
         assign jm[i] = hit_pos(jcmp_r[i], pos_r) && (jcmp_r[i].second == idx_r);
      end
   endgenerate

   // rising edge of any match raises the match event
   logic [3*SLOTS-1:0] m_prev_r;
   wire  [3*SLOTS-1:0] m_all   = {jm, im, pm};
   wire                m_rise  = |(m_all & ~m_prev_r);
   wire  [EV_W-1:0]    ev      = {m_rise, rev_wrap, fwd_wrap};

   // bus decode
   wire        wr_ctrl = reg_wr && (reg_addr == ADDR_CTRL);
   wire        wr_max  = reg_wr && (reg_addr == ADDR_MAXPOS);
   wire        wr_ien  = reg_wr && (reg_addr == ADDR_IRQ_EN);
   wire        wr_clr  = reg_wr && (reg_addr == ADDR_IRQ_CLR);
   wire [7:0]  cmp_off = reg_addr - ADDR_CMP_BASE;
   wire [7:0]  cmp_ix  = cmp_off >> 2;
   wire        cmp_hit = (reg_addr >= ADDR_CMP_BASE) && (cmp_ix < 8'(3*SLOTS))
                         && (cmp_off[1:0] == 2'h0);
   wire [EV_W-1:0] clr_m = wr_clr ? reg_wdata[EV_W-1:0] : '0;

   // registers written by software; set wins over clear in status
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ctrl_r   <= 3'h0;
         maxpos_r <= MAXPOS_RST;
         ien_r    <= '0;
         stat_r   <= '0;
         m_prev_r <= '0;
         for (int k = 0; k < SLOTS; k++)
         begin
            pcmp_r[k] <= '0;
            icmp_r[k] <= '0;
            jcmp_r[k] <= '0;
         end
      end
      else if (clk_en)
      begin
         m_prev_r <= m_all;
         stat_r   <= (stat_r & ~clr_m) | ev;
         if (wr_ctrl)
            ctrl_r <= reg_wdata[2:0];
         if (wr_max)
            maxpos_r <= reg_wdata[POS_W-1:0];
         if (wr_ien)
            ien_r <= reg_wdata[EV_W-1:0];
         if (reg_wr && cmp_hit)
         begin
            if (cmp_ix < 8'(SLOTS))
               pcmp_r[cmp_ix[1:0]] <= reg_wdata;
            else if (cmp_ix < 8'(2*SLOTS))
               icmp_r[2'(cmp_ix - 8'(SLOTS))] <= reg_wdata;
            else
               jcmp_r[2'(cmp_ix - 8'(2*SLOTS))] <= reg_wdata;
         end
      end
   end

   // read mux; unmapped reads return zero
   logic [31:0] rmux;
   always_comb
   begin
      rmux = 32'h0000_0000;
      if (cmp_hit)
      begin
         if (cmp_ix < 8'(SLOTS))
            rmux = pcmp_r[cmp_ix[1:0]];
         else if (cmp_ix < 8'(2*SLOTS))
            rmux = icmp_r[2'(cmp_ix - 8'(SLOTS))];
         else
            rmux = jcmp_r[2'(cmp_ix - 8'(2*SLOTS))];
      end
      else
         case (reg_addr)
            ADDR_CTRL:     rmux = {29'h0, ctrl_r};
            ADDR_MAXPOS:   rmux = {16'h0, maxpos_r};
            ADDR_POS:      rmux = {16'h0, pos_r};
            ADDR_IDX:      rmux = {16'h0, idx_r};
            ADDR_COND:     rmux = {28'h0, dir_r, encoder_condition_out};
            ADDR_IRQ_STAT: rmux = {29'h0, stat_r};
            ADDR_IRQ_EN:   rmux = {29'h0, ien_r};
            default:       rmux = 32'h0000_0000;
         endcase
   end

   // every output registered; matches refresh each cycle
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         reg_rdata             <= 32'h0000_0000;
         block_true_out        <= 1'b0;
         travel_sense_out      <= 1'b0;
         encoder_condition_out <= '0;
         position_value_out    <= '0;
         index_value_out       <= '0;
         position_match_slot   <= '0;
         index_match_slot      <= '0;
         joint_match_slot      <= '0;
         irq                   <= 1'b0;
      end
      else if (clk_en)
      begin
         reg_rdata             <= reg_rd ? rmux : 32'h0000_0000;
         block_true_out        <= enabled;
         travel_sense_out      <= dir_r;
         encoder_condition_out <= '{moving: cnt, last_wrap_rev: last_rev_r,
                                    enabled: enabled};
         position_value_out    <= pos_r;
         index_value_out       <= idx_r;
         position_match_slot   <= pm;
         index_match_slot      <= im;
         joint_match_slot      <= jm;
         irq                   <= |(((stat_r & ~clr_m) | ev) & ien_r);
      end
   end

endmodule // qpc_top

// ==== verif/qpc_top_assertions.sv ====
`timescale 1ns/1ps
// watches the counter outputs and the read port from the top ports only
module qpc_top_chk
   import qpc_pkg::*;
(
   input wire logic             clk,
   input wire logic             resetn,
   input wire logic             enable_in,
   input wire logic             reset_position_in,
   input wire logic             reset_index_in,
   input wire logic             reg_rd,
   input wire logic [31:0]      reg_rdata,
   input wire logic             block_true_out,
   input wire logic             travel_sense_out,
   input wire logic [POS_W-1:0] position_value_out,
   input wire logic [IDX_W-1:0] index_value_out
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   // position moves by one, wraps or clears; synchronisers need about 4 cycles
   a_block_true: assert property (
      enable_in [*8] |-> block_true_out)
      else $error("block not reported true while enabled");
   a_frozen_off: assert property (
      $changed(position_value_out) && position_value_out != 16'h0000
      |-> $past(block_true_out) || $past(block_true_out, 2) || $past(block_true_out, 3))
      else $error("position moved while disabled");
   a_rst_pos: assert property (
      reset_position_in [*8] |-> position_value_out == 16'h0000)
      else $error("position not cleared");
   a_rst_idx: assert property (
      reset_index_in [*8] |-> index_value_out == 16'h0000)
      else $error("index not cleared");
   a_dir_fwd: assert property (
      $changed(position_value_out)
      && position_value_out == $past(position_value_out) + 16'h0001
      |-> ##[0:2] travel_sense_out)
      else $error("direction not forward");
   a_dir_rev: assert property (
      $changed(position_value_out)
      && position_value_out == $past(position_value_out) - 16'h0001
      |-> ##[0:2] !travel_sense_out)
      else $error("direction not reverse");
   a_pos_step: assert property (
      $changed(position_value_out) |-> position_value_out == 16'h0000
      || 16'(position_value_out - $past(position_value_out)) inside {16'h0001, 16'hFFFF}
      || $changed(index_value_out))
      else $error("position jumped");
   a_idx_wrap: assert property (
      $changed(index_value_out) && index_value_out != 16'h0000
      |-> (index_value_out == $past(index_value_out) + 16'h0001
           && position_value_out == 16'h0000)
      || (index_value_out == $past(index_value_out) - 16'h0001
           && position_value_out != 16'h0000))
      else $error("index moved without wrap");
   a_rdata_idle: assert property (
      !$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
      else $error("read data outside read slot");
endmodule // qpc_top_chk

bind qpc_top qpc_top_chk qpc_top_chk_i
(
   .clk                (clk),
   .resetn             (resetn),
   .enable_in          (enable_in),
   .reset_position_in  (reset_position_in),
   .reset_index_in     (reset_index_in),
   .reg_rd             (reg_rd),
   .reg_rdata          (reg_rdata),
   .block_true_out     (block_true_out),
   .travel_sense_out   (travel_sense_out),
   .position_value_out (position_value_out),
   .index_value_out    (index_value_out)
);

// ==== verif/qpc_enc_model.sv ====
`timescale 1ns/1ps
// incremental encoder; one line changes per step so no step is ever dropped
module qpc_enc_model
(
   input wire logic  clk,
   input wire logic  resetn,
   input wire logic  fwd_req,
   input wire logic  rev_req,
   output logic [1:0] ab
);
   // gray walk forward 00,10,11,01 and back; ab[0] is A, ab[1] is B
   always_ff @(posedge clk or negedge resetn)
      if (!resetn)
         ab <= 2'h0;
      else if (fwd_req)
         ab <= {~ab[0], ab[1]};
      else if (rev_req)
         ab <= {ab[0], ~ab[1]};
endmodule // qpc_enc_model

// ==== verif/tb_qpc_top.sv ====
`timescale 1ns/1ps
module tb_qpc_top
   import qpc_pkg::*;
;
   localparam logic [15:0] MAXP = 16'h0003;
   logic clk, resetn, clk_en, enable_in, reset_position_in, reset_index_in;
   logic reg_wr, reg_rd, irq, block_true_out, travel_sense_out, fwd_req, rev_req, live;
   logic [1:0]       enc_ab;
   logic [7:0]       reg_addr;
   logic [31:0]      reg_wdata, reg_rdata, d;
   qpc_cond_type     encoder_condition_out;
   logic [15:0]      position_value_out, index_value_out, ep, ei;
   logic [2:0]       position_match_slot, index_match_slot, joint_match_slot;
   int               num_errors, checked;

   qpc_enc_model qpc_enc_model_i (.clk(clk), .resetn(resetn), .fwd_req(fwd_req),
      .rev_req(rev_req), .ab(enc_ab));
   qpc_top qpc_top_i (.clk(clk), .resetn(resetn), .clk_en(clk_en), .enc_ab(enc_ab),
      .enable_in(enable_in), .reset_position_in(reset_position_in),
      .reset_index_in(reset_index_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .block_true_out(block_true_out),
      .travel_sense_out(travel_sense_out), .encoder_condition_out(encoder_condition_out),
      .position_value_out(position_value_out), .index_value_out(index_value_out),
      .position_match_slot(position_match_slot), .index_match_slot(index_match_slot),
      .joint_match_slot(joint_match_slot), .irq(irq));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task end_sim;
      if (num_errors == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask

   task chk_all;
      logic [2:0] pm, im, jm;
      for (int i = 0; i < 3; i++)
      begin
         pm[i] = (ep == 16'(i + 1));
         im[i] = (ei == 16'(i));
         jm[i] = (ei == 16'h0001) && (ep == 16'(i));
      end
      chk(position_value_out, ep);
      chk(index_value_out, ei);
      chk(position_match_slot, pm);
      chk(index_match_slot, im);
      chk(joint_match_slot, jm);
   endtask

   // one encoder step; the expected counters follow only while enabled
   task step(input logic fwd);
      @(posedge clk);
      fwd_req <= fwd;
      rev_req <= !fwd;
      @(posedge clk);
      fwd_req <= 1'b0;
      rev_req <= 1'b0;
      if (live && fwd)
         {ei, ep} = (ep >= MAXP) ? {ei + 16'h0001, 16'h0000} : {ei, ep + 16'h0001};
      if (live && !fwd)
         {ei, ep} = (ep <= 16'h0001) ? {ei - 16'h0001, MAXP} : {ei, ep - 16'h0001};
      repeat (12) @(posedge clk);
      #1;
      if (live)
         chk(travel_sense_out, fwd);
      chk_all;
   endtask

   initial
   begin
      repeat (20000) @(posedge clk);
      num_errors++;
      end_sim;
   end

   initial
   begin
      {resetn, enable_in, reset_position_in, reset_index_in, reg_wr, reg_rd} = 6'h00;
      {fwd_req, rev_req, reg_addr, reg_wdata, ep, ei} = 0;
      clk_en = 1'b1;
      live = 1'b1;
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      rd(ADDR_MAXPOS, d);
      chk(d, 32'h0000FFFF);
      rd(8'hFC, d);
      chk(d, 32'h0);
      wr(ADDR_MAXPOS, {16'h0, MAXP});
      for (int i = 0; i < 3; i++)
      begin
         wr(8'(ADDR_CMP_BASE + 4 * i), 32'(i + 1));
         wr(8'(ADDR_CMP_BASE + 12 + 4 * i), 32'(i));
         wr(8'(ADDR_CMP_BASE + 24 + 4 * i), {16'h0001, 16'(i)});
      end
      enable_in <= 1'b1;
      repeat (10) @(posedge clk);
      #1 chk(block_true_out, 1'b1);
      chk(encoder_condition_out.enabled, 1'b1);
      chk_all;
      repeat (5) step(1'b1);
      repeat (6) step(1'b0);
      chk(encoder_condition_out.last_wrap_rev, 1'b1);
      rd(ADDR_POS, d);
      chk(d, {16'h0, ep});
      rd(ADDR_IDX, d);
      chk(d, {16'h0, ei});
      // sticky events stay masked until enabled, then clear on a write of ones
      rd(ADDR_IRQ_STAT, d);
      chk(d, 32'h7);
      chk(irq, 1'b0);
      wr(ADDR_IRQ_EN, 32'h1);
      repeat (3) @(posedge clk);
      #1 chk(irq, 1'b1);
      wr(ADDR_IRQ_CLR, 32'h7);
      repeat (3) @(posedge clk);
      #1 chk(irq, 1'b0);
      rd(ADDR_IRQ_STAT, d);
      chk(d, 32'h0);
      reset_position_in <= 1'b1;
      repeat (10) @(posedge clk);
      reset_position_in <= 1'b0;
      ep = 16'h0;
      #1 chk_all;
      reset_index_in <= 1'b1;
      repeat (10) @(posedge clk);
      reset_index_in <= 1'b0;
      ei = 16'h0;
      #1 chk_all;
      enable_in <= 1'b0;
      live = 1'b0;
      repeat (10) @(posedge clk);
      #1 chk(block_true_out, 1'b0);
      step(1'b1);
      wr(ADDR_CTRL, 32'h1);
      repeat (8) @(posedge clk);
      #1 chk(block_true_out, 1'b1);
      // clock enable low freezes everything; the pending step counts once it returns
      clk_en <= 1'b0;
      step(1'b0);
      clk_en <= 1'b1;
      {live, ei, ep} = {1'b1, 16'hFFFF, MAXP};
      repeat (12) @(posedge clk);
      #1 chk(travel_sense_out, 1'b0);
      chk_all;
      // software reset bits clear both counters
      wr(ADDR_CTRL, 32'h7);
      {ei, ep} = 32'h0;
      repeat (2) @(posedge clk);
      #1 chk_all;
      rd(ADDR_COND, d);
      chk(d, 32'h0000_0003);
      end_sim;
   end
endmodule // tb_qpc_top
